/* src/digital_integration_sampler.sv */
// Digital integration sampler: region timing, accumulation, result delivery and APB registers.
`include "dis_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module digital_integration_sampler
	import dis_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        slot_start,
	input  wire logic        slot_sel,
	input  wire logic        adc_valid,
	input  wire logic [13:0] adc_data,
	output logic             conv_start,
	output logic             sample_valid,
	output logic [31:0]      sample_data,
	output logic             fifo_wr,
	output logic [31:0]      fifo_data,
	output logic             integ_buffer_mode,
	output logic             bypass_bpf,
	output logic             bypass_integ,
	output logic             busy
);

	sampler_state_t q;
	sampler_state_t n;

	logic [7:0]  idx;
	logic        single;
	logic        gapped;
	logic [23:0] region_cfg;
	logic [11:0] s_dark1;
	logic [11:0] e_dark1;
	logic [11:0] s_lit;
	logic [11:0] e_lit;
	logic [11:0] s_dark2;
	logic [11:0] e_all;
	logic [11:0] win;
	logic [11:0] gap;
	region_t     region;
	logic [31:0] smp;
	logic [2:0]  fmt;
	logic        slot_on;

	assign idx = paddr[9:2];
	assign smp = {18'h00000, adc_data};
	assign region_cfg = q.slot ? q.region_b : q.region_a;
	assign single = q.slot ? q.int_cfg[`BIT_SINGLE_PAIR_B] : q.int_cfg[`BIT_SINGLE_PAIR_A];
	assign gapped = q.int_cfg[`BIT_GAPPED];
	assign fmt = q.slot ? q.fifo_cfg[8:6] : q.fifo_cfg[4:2];
	assign slot_on = slot_sel ? q.int_en[`BIT_INT_EN_B] : q.int_en[`BIT_INT_EN_A];

	// Region boundaries in conversion steps; field layout is {gap, window, offset}.
	always_comb begin
		win = {4'h0, region_cfg[15:8]};
		gap = gapped ? {4'h0, region_cfg[23:16]} : 12'h000;
		s_dark1 = {4'h0, region_cfg[7:0]} + `DI_START_STEPS;
		e_dark1 = s_dark1 + win;
		s_lit = e_dark1 + gap;
		e_lit = single ? s_lit + win : s_lit + {win[10:0], 1'b0};
		s_dark2 = e_lit + gap;
		e_all = single ? e_lit : s_dark2 + win;
		if (q.step >= s_dark1 && q.step < e_dark1) begin
			region = RG_DARK;
		end else if (q.step >= s_lit && q.step < e_lit) begin
			region = RG_LIT;
		end else if (!single && q.step >= s_dark2 && q.step < e_all) begin
			region = RG_DARK;
		end else begin
			region = RG_NONE;
		end
	end

	always_comb begin
		n = q;
		n.conv_start = 1'b0;
		n.sample_valid = 1'b0;
		n.fifo_wr = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;

		// APB: the answer is prepared in the setup cycle and given in the first access cycle.
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.prdata = 32'h00000000;
			case (idx)
				`IDX_SLOT_A_FE_MODE: n.prdata = {16'h0000, q.mode_a};
				`IDX_SLOT_A_FE_CONN: n.prdata = {16'h0000, q.conn_a};
				`IDX_SLOT_B_FE_MODE: n.prdata = {16'h0000, q.mode_b};
				`IDX_SLOT_B_FE_CONN: n.prdata = {16'h0000, q.conn_b};
				`IDX_CONV_TIMING:    n.prdata = {16'h0000, q.conv_timing};
				`IDX_INT_ENABLE:     n.prdata = {16'h0000, q.int_en};
				`IDX_INT_SAMPLING:   n.prdata = {16'h0000, q.int_cfg};
				`IDX_FIFO_FORMAT:    n.prdata = {16'h0000, q.fifo_cfg};
				`IDX_SLOT_A_REGION:  n.prdata = {8'h00, q.region_a};
				`IDX_SLOT_B_REGION:  n.prdata = {8'h00, q.region_b};
				`IDX_A_RES_0, `IDX_A_RES_1, `IDX_A_RES_2: n.prdata = q.res_a;
				`IDX_A_BG_0, `IDX_A_BG_1, `IDX_A_BG_2: n.prdata = q.bg_a;
				`IDX_B_RES_0, `IDX_B_RES_1, `IDX_B_RES_2: n.prdata = q.res_b;
				`IDX_B_BG_0, `IDX_B_BG_1, `IDX_B_BG_2: n.prdata = q.bg_b;
				default: n.pslverr = 1'b1;
			endcase
		end

		if (psel && penable && q.pready && pwrite && !q.pslverr) begin
			case (idx)
				`IDX_SLOT_A_FE_MODE: n.mode_a = pwdata[15:0];
				`IDX_SLOT_A_FE_CONN: n.conn_a = pwdata[15:0];
				`IDX_SLOT_B_FE_MODE: n.mode_b = pwdata[15:0];
				`IDX_SLOT_B_FE_CONN: n.conn_b = pwdata[15:0];
				`IDX_CONV_TIMING:    n.conv_timing = pwdata[15:0];
				`IDX_INT_ENABLE:     n.int_en = pwdata[15:0];
				`IDX_INT_SAMPLING:   n.int_cfg = pwdata[15:0];
				`IDX_FIFO_FORMAT:    n.fifo_cfg = pwdata[15:0];
				`IDX_SLOT_A_REGION:  n.region_a = pwdata[23:0];
				`IDX_SLOT_B_REGION:  n.region_b = pwdata[23:0];
				default: n.pslverr = 1'b0;
			endcase
		end

		case (q.st)
			ST_IDLE: begin
				// A slot outside digital integration never starts, so its region and format setup is unused.
				if (slot_start && slot_on) begin
					n.st = ST_RUN;
					n.slot = slot_sel;
					n.tick = 7'h00;
					n.step = 12'h000;
					n.acc = 32'h00000000;
					n.bg_acc = 32'h00000000;
					n.busy = 1'b1;
				end
			end
			ST_RUN: begin
				// Conversions are only requested while the converter runs at 1 MHz.
				if (q.conv_timing == `CONV_TIMING_1MHZ) begin
					if (q.tick == 7'(`CONV_CYCLES - 1)) begin
						n.tick = 7'h00;
						n.conv_start = 1'b1;
					end else begin
						n.tick = q.tick + 7'h01;
					end
				end
				if (adc_valid) begin
					n.step = q.step + 12'h001;
					if (region == RG_DARK) begin
						n.acc = q.acc - smp;
						n.bg_acc = q.bg_acc + smp;
					end else if (region == RG_LIT) begin
						n.acc = q.acc + smp;
					end
				end
				if (q.step >= e_all) begin
					n.sample_valid = 1'b1;
					n.sample_data = q.acc;
					if (q.slot) begin
						n.res_b = q.acc;
						n.bg_b = q.bg_acc;
					end else begin
						n.res_a = q.acc;
						n.bg_a = q.bg_acc;
					end
					n.st = ST_IDLE;
					n.busy = 1'b0;
					if (fmt == `FIFO_FMT_16BIT) begin
						n.fifo_wr = 1'b1;
						n.fifo_data = {q.bg_acc[15:0], q.acc[15:0]};
					end else if (fmt == `FIFO_FMT_32BIT) begin
						n.fifo_wr = 1'b1;
						n.fifo_data = q.acc;
						n.st = ST_EMIT2;
						n.busy = 1'b1;
					end
				end
			end
			ST_EMIT2: begin
				n.fifo_wr = 1'b1;
				n.fifo_data = q.bg_acc;
				n.st = ST_IDLE;
				n.busy = 1'b0;
			end
			default: begin
				n.st = ST_IDLE;
				n.busy = 1'b0;
			end
		endcase

		// Analog path controls follow the slot that is being sampled.
		n.buf_mode = (n.slot ? n.mode_b[15:8] : n.mode_a[15:8]) == `FE_MODE_BUFFER;
		n.byp_bpf = (n.slot ? n.conn_b : n.conn_a) != `FE_CONN_NORMAL;
		n.byp_int = (n.slot ? n.conn_b : n.conn_a) == `FE_CONN_NO_BPF_INT;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.mode_a <= `RST_REG16;
			q.mode_b <= `RST_REG16;
			q.region_a <= `RST_REGION;
			q.region_b <= `RST_REGION;
		end else begin
			q <= n;
		end
	end

	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign prdata = q.prdata;
	assign conv_start = q.conv_start;
	assign sample_valid = q.sample_valid;
	assign sample_data = q.sample_data;
	assign fifo_wr = q.fifo_wr;
	assign fifo_data = q.fifo_data;
	assign integ_buffer_mode = q.buf_mode;
	assign bypass_bpf = q.byp_bpf;
	assign bypass_integ = q.byp_int;
	assign busy = q.busy;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	a_apb_answer_next: assert property ((psel && !penable) |=> pready)
		else $error("setup cycle not answered in next cycle");
	a_apb_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_conv_spacing: assert property (conv_start |=> !conv_start [*8])
		else $error("conversions requested too close together");
	a_conv_needs_timing: assert property (conv_start |-> $past(q.conv_timing) == `CONV_TIMING_1MHZ)
		else $error("conversion requested without 1 MHz timing");
	a_dark_subtract: assert property ((q.st == ST_RUN && adc_valid && region == RG_DARK && q.step < e_all)
		|=> q.acc == $past(q.acc) - $past(smp))
		else $error("dark sample not subtracted");
	a_lit_add: assert property ((q.st == ST_RUN && adc_valid && region == RG_LIT && q.step < e_all)
		|=> q.acc == $past(q.acc) + $past(smp))
		else $error("lit sample not added");
	a_dark_background: assert property ((q.st == ST_RUN && adc_valid && region == RG_DARK && q.step < e_all)
		|=> q.bg_acc == $past(q.bg_acc) + $past(smp))
		else $error("dark sample missing from background");
	a_dark_first_step: assert property ((q.st == ST_RUN && q.step == s_dark1 && win != 12'h000)
		|-> region == RG_DARK)
		else $error("dark region does not start at offset plus nine");
	a_gap_closed: assert property (!gapped |-> s_lit == e_dark1)
		else $error("gap present in continuous timing");
	a_sample_delivered: assert property ((q.st == ST_RUN && q.step >= e_all)
		|=> sample_valid && sample_data == $past(q.acc) && q.st != ST_RUN)
		else $error("final sum not delivered");
	a_wide_two_words: assert property ((fifo_wr && q.st == ST_EMIT2) |=> fifo_wr && fifo_data == $past(q.bg_acc))
		else $error("background word missing after result word");
	a_disabled_slot: assert property ((q.st == ST_IDLE && slot_start && !slot_on) |=> q.st == ST_IDLE)
		else $error("disabled slot started integration");
	a_buffer_mode: assert property ((q.slot == 1'b0 && q.mode_a[15:8] == `FE_MODE_BUFFER
		&& $stable(q.mode_a) && $stable(q.slot)) |-> integ_buffer_mode)
		else $error("integrator not set as buffer");

	c_single_pair: cover property (q.st == ST_RUN && single ##1 sample_valid);
	c_double_gapped: cover property (q.st == ST_RUN && !single && gapped ##1 sample_valid);
	c_two_word_fifo: cover property (fifo_wr ##1 fifo_wr);
	c_apb_write: cover property (psel && penable && pready && pwrite);

endmodule

`default_nettype wire

/* src/dis_consts.svh */
// Offsets, field positions, reset values and timing counts of the integration sampler.
`ifndef DIS_CONSTS_SVH
`define DIS_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_SLOT_A_FE_MODE   8'h42
`define IDX_SLOT_A_FE_CONN   8'h43
`define IDX_SLOT_B_FE_MODE   8'h44
`define IDX_SLOT_B_FE_CONN   8'h45
`define IDX_CONV_TIMING      8'h4e
`define IDX_INT_ENABLE       8'h58
`define IDX_INT_SAMPLING     8'h5a
`define IDX_FIFO_FORMAT      8'h11
`define IDX_SLOT_A_REGION    8'h80
`define IDX_SLOT_B_REGION    8'h81
`define IDX_A_RES_0          8'h64
`define IDX_A_BG_0           8'h65
`define IDX_A_RES_1          8'h70
`define IDX_A_BG_1           8'h71
`define IDX_A_RES_2          8'h74
`define IDX_A_BG_2           8'h75
`define IDX_B_RES_0          8'h68
`define IDX_B_BG_0           8'h69
`define IDX_B_RES_1          8'h78
`define IDX_B_BG_1           8'h79
`define IDX_B_RES_2          8'h7c
`define IDX_B_BG_2           8'h7d

// Field positions.
`define BIT_SINGLE_PAIR_A    5
`define BIT_SINGLE_PAIR_B    6
`define BIT_GAPPED           7
`define BIT_INT_EN_A         12
`define BIT_INT_EN_B         13

// Field codes.
`define FE_MODE_NORMAL       8'h1c
`define FE_MODE_BUFFER       8'h1d
`define FE_CONN_NORMAL       16'hada5
`define FE_CONN_NO_BPF       16'hae65
`define FE_CONN_NO_BPF_INT   16'hb065
`define CONV_TIMING_1MHZ     16'h0040
`define FIFO_FMT_16BIT       3'h3
`define FIFO_FMT_32BIT       3'h4
`define DI_START_STEPS       12'h009

// Reset values.
`define RST_REG16            16'h0000
`define RST_REGION           24'h000000

// Timing.
`define CLK_PERIOD_NS        10
`define CONV_PERIOD_NS       1000
`define CONV_CYCLES          (`CONV_PERIOD_NS / `CLK_PERIOD_NS)

`endif

/* src/dis_pkg.sv */
// Types of the integration sampler.
package dis_pkg;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RUN   = 2'b01,
		ST_EMIT2 = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		RG_NONE = 2'b00,
		RG_DARK = 2'b01,
		RG_LIT  = 2'b10
	} region_t;

	typedef struct packed {
		logic [15:0] mode_a;
		logic [15:0] conn_a;
		logic [15:0] mode_b;
		logic [15:0] conn_b;
		logic [15:0] conv_timing;
		logic [15:0] int_en;
		logic [15:0] int_cfg;
		logic [15:0] fifo_cfg;
		logic [23:0] region_a;
		logic [23:0] region_b;
		logic [31:0] res_a;
		logic [31:0] bg_a;
		logic [31:0] res_b;
		logic [31:0] bg_b;
		seq_state_t  st;
		logic        slot;
		logic [6:0]  tick;
		logic [11:0] step;
		logic [31:0] acc;
		logic [31:0] bg_acc;
		logic        conv_start;
		logic        sample_valid;
		logic [31:0] sample_data;
		logic        fifo_wr;
		logic [31:0] fifo_data;
		logic        buf_mode;
		logic        byp_bpf;
		logic        byp_int;
		logic        busy;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} sampler_state_t;

endpackage

/* tb/adc_model.sv */
// Converter stand-in that answers each conversion request with one 14-bit result.
`timescale 1ns/1ps
`default_nettype none

module adc_model (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        conv_start,
	input  wire logic        restart,
	input  wire logic [13:0] base,
	input  wire logic        slow,
	output logic             adc_valid,
	output logic [13:0]      adc_data
);
	int k;
	int wait_n;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			k <= 0;
			wait_n <= 0;
			adc_valid <= 1'b0;
			adc_data <= 14'h0000;
		end else begin
			adc_valid <= 1'b0;
			// Outside its valid cycle the data is scrambled so that nothing relies on it.
			adc_data <= ~adc_data;
			if (restart) begin
				k <= 0;
			end
			if (conv_start) begin
				wait_n <= slow ? 40 : 2;
			end else if (wait_n > 0) begin
				wait_n <= wait_n - 1;
			end
			if (!conv_start && wait_n == 1) begin
				adc_valid <= 1'b1;
				adc_data <= base + 14'(k * 37);
				k <= k + 1;
			end
		end
	end
endmodule

`default_nettype wire

/* tb/digital_integration_sampler_tb.sv */
// Self-checking bench of the integration sampler against a region model.
`include "dis_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module digital_integration_sampler_tb;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic        slot_start = 1'b0;
	logic        slot_sel = 1'b0;
	logic [13:0] base = 14'h0000;
	logic        slow = 1'b0;
	wire logic        pready, pslverr, adc_valid, conv_start, sample_valid, fifo_wr;
	wire logic        integ_buffer_mode, bypass_bpf, bypass_integ, busy;
	wire logic [31:0] prdata, sample_data, fifo_data;
	wire logic [13:0] adc_data;
	int          errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          lastc = -1;
	int          gq[$];
	logic [31:0] fq[$];
	logic [31:0] sq[$];
	logic [7:0]  ra[2][3] = '{'{`IDX_A_RES_0, `IDX_A_RES_1, `IDX_A_RES_2},
		'{`IDX_B_RES_0, `IDX_B_RES_1, `IDX_B_RES_2}};
	logic [7:0]  rl[9] = '{`IDX_SLOT_A_FE_MODE, `IDX_SLOT_A_FE_CONN, `IDX_SLOT_B_FE_MODE,
		`IDX_SLOT_B_FE_CONN, `IDX_CONV_TIMING, `IDX_INT_ENABLE, `IDX_INT_SAMPLING,
		`IDX_SLOT_A_REGION, `IDX_SLOT_B_REGION};

	digital_integration_sampler u_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .slot_start(slot_start), .slot_sel(slot_sel),
		.adc_valid(adc_valid), .adc_data(adc_data), .conv_start(conv_start),
		.sample_valid(sample_valid), .sample_data(sample_data), .fifo_wr(fifo_wr),
		.fifo_data(fifo_data), .integ_buffer_mode(integ_buffer_mode),
		.bypass_bpf(bypass_bpf), .bypass_integ(bypass_integ), .busy(busy));
	adc_model u_adc (.clk(clk), .arst_n(arst_n), .conv_start(conv_start),
		.restart(slot_start), .base(base), .slow(slow), .adc_valid(adc_valid),
		.adc_data(adc_data));

	always #5 clk = ~clk;

	// Outputs are picked up mid-cycle, where they have settled after the launching edge.
	always @(negedge clk) begin
		cyc++;
		if (fifo_wr === 1'b1) fq.push_back(fifo_data);
		if (sample_valid === 1'b1) sq.push_back(sample_data);
		if (conv_start === 1'b1) begin
			if (lastc >= 0) gq.push_back(cyc - lastc);
			lastc = cyc;
		end
	end

	task automatic wrap_up;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// The answer is looked at and taken mid-cycle; the bus is released at the rising edge that follows.
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 50) begin
			errors++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 32'h0, r, e);
		chk(r, exp);
	endtask

	task automatic pulse_start(input logic s);
		@(posedge clk);
		slot_start <= 1'b1;
		slot_sel <= s;
		@(posedge clk);
		slot_start <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic run(input int s, sg, gp, off, w, g, fmt, sl, input logic [15:0] cn);
		int acc, bg, o9, ge, e, k, d, n, j, lit0;
		logic [31:0] ef[$];
		logic [13:0] bv;
		acc = 0;
		bg = 0;
		bv = 14'($urandom);
		base <= bv;
		slow <= sl[0];
		wr(`IDX_INT_ENABLE, 32'hffff0000 | (1 << (12 + s)));
		wr(`IDX_INT_SAMPLING, (gp << 7) | ((s ? !sg : sg) << 5) | ((s ? sg : !sg) << 6));
		wr(s ? `IDX_SLOT_B_REGION : `IDX_SLOT_A_REGION, {8'h0, 8'(g), 8'(w), 8'(off)});
		wr(`IDX_FIFO_FORMAT, fmt << (s ? 6 : 2));
		wr(s ? `IDX_SLOT_B_FE_MODE : `IDX_SLOT_A_FE_MODE, s ? 16'h1c00 : 16'h1d00);
		wr(s ? `IDX_SLOT_B_FE_CONN : `IDX_SLOT_A_FE_CONN, {16'h0, cn});
		o9 = off + 9;
		ge = gp ? g : 0;
		lit0 = o9 + w + ge;
		e = sg ? lit0 + w : lit0 + 3 * w + ge;
		for (k = 0; k < e; k++) begin
			d = (bv + k * 37) & 16'h3fff;
			if ((k >= o9 && k < o9 + w) || (!sg && k >= lit0 + 2 * w + ge)) begin
				acc -= d;
				bg += d;
			end else if (k >= lit0 && k < lit0 + (sg ? w : 2 * w)) begin
				acc += d;
			end
		end
		if (fmt == 4) ef = '{acc, bg};
		if (fmt == 3) ef = '{{bg[15:0], acc[15:0]}};
		fq.delete();
		sq.delete();
		gq.delete();
		lastc = -1;
		pulse_start(s[0]);
		chk(busy, 1);
		chk(integ_buffer_mode, !s);
		chk(bypass_bpf, cn != 16'hada5);
		chk(bypass_integ, cn == 16'hb065);
		for (n = 0; n < 20000 && busy !== 1'b0; n++) @(posedge clk);
		if (n == 20000) begin
			errors++;
			wrap_up();
		end
		repeat (2) @(posedge clk);
		chk(sq.size(), 1);
		chk(sq[0], acc);
		chk(fq.size(), ef.size());
		foreach (ef[i]) chk(fq[i], ef[i]);
		chk(gq[0], `CONV_CYCLES);
		// The host saturation test must judge the delivered sum as it judges the model sum.
		if (w > 0 && sg) chk(32'((($signed(sq[0]) / w) + bg / w) > 'h3fff), 32'(((acc / w) + bg / w) > 'h3fff));
		if (w > 0 && !sg) chk(32'((($signed(sq[0]) / (2 * w)) + bg / (2 * w)) > 'h3fff), 32'(((acc / (2 * w)) + bg / (2 * w)) > 'h3fff));
		for (j = 0; j < 3; j++) begin
			rdc(ra[s][j], acc);
			rdc(ra[s][j] + 8'h01, bg);
		end
		$display("test done: slot %0d single %0d gapped %0d", s, sg, gp);
	endtask

	initial begin
		logic [31:0] r;
		logic        e;
		void'($urandom(94));
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		foreach (rl[i]) rdc(rl[i], 32'h0);
		foreach (rl[i]) begin
			r = $urandom;
			wr(rl[i], r);
			rdc(rl[i], r & (i > 6 ? 32'h00ffffff : 32'h0000ffff));
		end
		apb(1'b1, 8'h30, 32'h1234, r, e);
		chk(e, 1);
		apb(1'b0, 8'h30, 32'h0, r, e);
		chk(r, 0);
		chk(e, 1);
		$display("test done: registers");
		wr(`IDX_CONV_TIMING, `CONV_TIMING_1MHZ);
		wr(`IDX_INT_ENABLE, 32'h1 << `BIT_INT_EN_A);
		pulse_start(1'b1);
		chk(busy, 0);
		$display("test done: disabled slot");
		run(0, 1, 0, 0, 1, 0, 4, 0, 16'hae65);
		run(1, 1, 1, 2, 3, 2, 3, 1, 16'hb065);
		run(0, 0, 0, 1, 2, 2, 4, 0, 16'hada5);
		run(1, 0, 1, 0, 2, 3, 0, 0, 16'hae65);
		run(0, 0, 1, 3, 3, 1, 3, 1, 16'hb065);
		run(1, 1, 0, 0, 0, 0, 4, 0, 16'hae65);
		wrap_up();
	end
endmodule

`default_nettype wire
